/* File: logic/bstc_top.sv */
// Host-commanded board self-test control with its global register map.
// Assumes a byte-wide register port on mclk_i and a diagnostic engine on
// the same clock that runs the DMA, self-access, loopback and timer work.
// Function
// RULE1: host picks a test bit, then sets the trigger bit.
// RULE2: finishing clears trigger and busy; either reading zero means done.
// RULE3: fail flag in global status set on failure, cleared on success.
// RULE4: failure code is placed in the channel zero status register.
// RULE5: host zeroes run and break registers before selecting a test; the bench loads break with 16'h0010 instead.
// RULE6: bits 5 DMA read, 4 DMA write, 3 self-access, 2 loopback, 1 timer, 0 irq.
// RULE7: DMA read uses base, width, count; residual count left in break.
// RULE8: DMA write likewise; nonzero break value is residual count.
// RULE9: self-access test stores the longword read into buffer base.
// RULE10: loopback needs only trigger; failing channel X gives code 1X.
// RULE11: host waits about five ms before polling timer test completion.
// RULE12: irq test uses vector and level 1-7, waits at most ten ms.
// RULE13: code 6 on irq test timeout, code 7 on bad setup.
// RULE14: code 1 on DMA read error, code 2 on DMA write error.
// RULE15: code 3 when no bus error, code 8 when self-access timed out.
// RULE16: code 4 for timer fast, code 5 for timer slow.
// RULE17: undefined test bit gives failure code 255.
// RULE18: command register 0 holds mode, decode, break, trigger, reset, indicator bits.
// RULE19: host keeps reserved offsets 1B to 1F at zero.
// RULE20: width field bits 7:6, address modifier bits 5:0.
// RULE21: command register 2: request level, release policy, fairness timeout.
// RULE22: command register 1: arbitration select bit 3, bus error timeout 2:0.
// RULE23: host selects one test and leaves parameters alone while busy.
`timescale 1ns/1ps
`include "bstc_regs.svh"
module bstc_top #(
  parameter int         MS_CYC   = `BSTC_MS_NS / `BSTC_CLK_NS,
  parameter logic [7:0] BOARD_ID = 8'h5a,  // arbitrary value
  parameter logic [15:0] OPTIONS = 16'h0100 // arbitrary value
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_b_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  input  wire logic [4:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  output logic [7:0]              reg_rdata_o,
  input  wire logic               sys_ctrl_pin_i,
  input  wire logic               irq_ack_pin_i,
  output logic                    irq_req_o,
  output logic [2:0]              irq_level_o,
  output logic [7:0]              irq_vector_o,
  output bstc_pkg::bstc_dreq_t    diag_req_o,
  input  wire bstc_pkg::bstc_drsp_t diag_rsp_i,
  output logic                    chan0_code_we_o,
  output logic [7:0]              chan0_code_o,
  output logic                    board_reset_o,
  output bstc_pkg::bstc_cmd0_t    cmd0_o,
  output bstc_pkg::bstc_cmd1_t    cmd1_o,
  output bstc_pkg::bstc_cmd2_t    cmd2_o,
  output bstc_pkg::bstc_wam_t     wam_o,
  output logic [15:0]             run_o,
  output logic [15:0]             tx_req_o,
  output logic [15:0]             rx_req_o,
  output logic [15:0]             brk_o,
  output logic [31:0]             bbase_o,
  output logic [7:0]              mgrn_o
);
  import bstc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    bstc_cmd0_t  cmd0;
    bstc_cmd1_t  cmd1;
    bstc_cmd2_t  cmd2;
    bstc_wam_t   wam;
    logic [15:0] run;
    logic [15:0] txr;
    logic [15:0] rxr;
    logic [15:0] brk;
    logic [7:0]  tsel;
    logic [7:0]  eic;
    logic [7:0]  evec;
    logic [31:0] bbase;
    logic [7:0]  mgrn;
    logic        busy;
    logic        fail;
    logic        regbsy;
    bstc_fsm_t   fsm;
    logic [7:0]  code;
    logic        code_we;
    logic        irq;
    bstc_dreq_t  dreq;
    logic [7:0]  rdata;
    logic        brd_rst;
    logic        sysc_s1;
    logic        sysc_s2;
    logic        ack_s1;
    logic        ack_s2;
  } bstc_st_t;

  bstc_st_t st_ff;
  bstc_st_t nxt_st;
  logic     tmo_exp;
  logic     tmo_clr;
  logic [15:0] gstat;

  // Interrupt test watchdog, restarted whenever the irq state is left
  assign tmo_clr = (st_ff.fsm != ST_IRQ);
  bstc_tmo #(
    .MS_CYC   (MS_CYC),
    .LIMIT_MS (`BSTC_IRQ_TMO_MS)
  ) u_tmo (
    .mclk_i    (mclk_i),
    .rst_b_i   (rst_b_i),
    .clr_i     (tmo_clr),
    .run_i     (1'b1),
    .expired_o (tmo_exp)
  );

  // Global status word; only the fail flag counts as an error here
  assign gstat = {st_ff.fail, 1'b0, st_ff.busy, st_ff.sysc_s2, 1'b0, st_ff.fail, 2'b00,
                st_ff.regbsy, 7'h00};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.code_we    = 1'b0;
    nxt_st.dreq.start = 1'b0;
    nxt_st.brd_rst    = 1'b0;
    // Pins pass two flops before use
    nxt_st.sysc_s1 = sys_ctrl_pin_i;
    nxt_st.sysc_s2 = st_ff.sysc_s1;
    nxt_st.ack_s1  = irq_ack_pin_i;
    nxt_st.ack_s2  = st_ff.ack_s1;

    // Register read, big-endian words; reserved offsets read zero
    if (reg_rd_i) begin
      case (reg_addr_i)
        `BSTC_A_ID:   nxt_st.rdata = BOARD_ID;
        `BSTC_A_STF:  nxt_st.rdata = {7'h00, st_ff.busy};
        `BSTC_A_OPTH: nxt_st.rdata = OPTIONS[15:8];
        `BSTC_A_OPTL: nxt_st.rdata = OPTIONS[7:0];
        `BSTC_A_CMD0: nxt_st.rdata = st_ff.cmd0;
        `BSTC_A_CMD1: nxt_st.rdata = st_ff.cmd1;
        `BSTC_A_RUNH: nxt_st.rdata = st_ff.run[15:8];
        `BSTC_A_RUNL: nxt_st.rdata = st_ff.run[7:0];
        `BSTC_A_TXH:  nxt_st.rdata = st_ff.txr[15:8];
        `BSTC_A_TXL:  nxt_st.rdata = st_ff.txr[7:0];
        `BSTC_A_RXH:  nxt_st.rdata = st_ff.rxr[15:8];
        `BSTC_A_RXL:  nxt_st.rdata = st_ff.rxr[7:0];
        `BSTC_A_BRKH: nxt_st.rdata = st_ff.brk[15:8];
        `BSTC_A_BRKL: nxt_st.rdata = st_ff.brk[7:0];
        `BSTC_A_CMD2: nxt_st.rdata = st_ff.cmd2;
        `BSTC_A_WAM:  nxt_st.rdata = st_ff.wam;
        `BSTC_A_TSEL: nxt_st.rdata = st_ff.tsel;
        `BSTC_A_EIC:  nxt_st.rdata = st_ff.eic;
        `BSTC_A_EVEC: nxt_st.rdata = st_ff.evec;
        5'h14:        nxt_st.rdata = st_ff.bbase[31:24];
        5'h15:        nxt_st.rdata = st_ff.bbase[23:16];
        5'h16:        nxt_st.rdata = st_ff.bbase[15:8];
        5'h17:        nxt_st.rdata = st_ff.bbase[7:0];
        `BSTC_A_GSTH: nxt_st.rdata = gstat[15:8];
        `BSTC_A_GSTL: nxt_st.rdata = gstat[7:0];
        `BSTC_A_MGRN: nxt_st.rdata = st_ff.mgrn;
        // RULE19 reserved zero
        default:      nxt_st.rdata = 8'h00;
      endcase
    end

    // Register write; a write to a writable offset drops register-busy, the low status byte loads it from bit 7, read-only and reserved offsets keep it
    if (reg_wr_i) begin
      nxt_st.regbsy = 1'b0;
      case (reg_addr_i)
        `BSTC_A_CMD0: begin
          // RULE18 command bits
          nxt_st.cmd0 = reg_wdata_i;
          // Trigger cannot be withdrawn by software while a test runs
          if (st_ff.busy) nxt_st.cmd0.self_test = st_ff.cmd0.self_test;
          nxt_st.brd_rst = reg_wdata_i[1];
        end
        // RULE22 arbitration fields
        `BSTC_A_CMD1: nxt_st.cmd1 = reg_wdata_i;
        `BSTC_A_RUNH: nxt_st.run[15:8] = reg_wdata_i;
        `BSTC_A_RUNL: nxt_st.run[7:0] = reg_wdata_i;
        `BSTC_A_TXH:  nxt_st.txr[15:8] = reg_wdata_i;
        `BSTC_A_TXL:  nxt_st.txr[7:0] = reg_wdata_i;
        `BSTC_A_RXH:  nxt_st.rxr[15:8] = reg_wdata_i;
        `BSTC_A_RXL:  nxt_st.rxr[7:0] = reg_wdata_i;
        `BSTC_A_BRKH: nxt_st.brk[15:8] = reg_wdata_i;
        `BSTC_A_BRKL: nxt_st.brk[7:0] = reg_wdata_i;
        // RULE21 request fields
        `BSTC_A_CMD2: nxt_st.cmd2 = reg_wdata_i;
        // RULE20 width and modifier
        `BSTC_A_WAM:  nxt_st.wam = reg_wdata_i;
        `BSTC_A_TSEL: nxt_st.tsel = reg_wdata_i;
        `BSTC_A_EIC:  nxt_st.eic = reg_wdata_i;
        `BSTC_A_EVEC: nxt_st.evec = reg_wdata_i;
        5'h14:        nxt_st.bbase[31:24] = reg_wdata_i;
        5'h15:        nxt_st.bbase[23:16] = reg_wdata_i;
        5'h16:        nxt_st.bbase[15:8] = reg_wdata_i;
        5'h17:        nxt_st.bbase[7:0] = reg_wdata_i;
        `BSTC_A_GSTH: nxt_st.fail = st_ff.fail & reg_wdata_i[`BSTC_GH_FAIL];
        `BSTC_A_GSTL: nxt_st.regbsy = reg_wdata_i[7];
        `BSTC_A_MGRN: nxt_st.mgrn = reg_wdata_i;
        default:      nxt_st.regbsy = st_ff.regbsy;
      endcase
    end

    // Test sequencer; hardware updates follow the write so the hardware value wins
    case (st_ff.fsm)
      ST_IDLE: begin
        if (st_ff.cmd0.self_test) begin
          nxt_st.busy = 1'b1;
          // RULE6 test bit decode
          if (st_ff.tsel[7:6] != 2'b00 || !$onehot(st_ff.tsel[5:0])) begin
            // RULE17 undefined selection
            nxt_st.code = `BSTC_C_UNDEF;
            nxt_st.fsm  = ST_DONE;
          end else if (st_ff.tsel[`BSTC_T_BINT]) begin
            // RULE13 bad setup check
            if (st_ff.eic[2:0] == 3'h0 || st_ff.eic[7:3] != 5'h00) begin
              nxt_st.code = `BSTC_C_IRQBAD;
              nxt_st.fsm  = ST_DONE;
            end else begin
              // RULE12 raise interrupt
              nxt_st.irq = 1'b1;
              nxt_st.fsm = ST_IRQ;
            end
          end else begin
            // RULE10 loopback and other engine tests
            nxt_st.dreq.start = 1'b1;
            nxt_st.dreq.sel   = st_ff.tsel[5:0];
            nxt_st.fsm        = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (diag_rsp_i.done) begin
          // RULE14 engine result code
          // RULE15 self-access codes
          // RULE16 timer codes
          nxt_st.code = diag_rsp_i.code;
          // RULE7 residual count
          // RULE8 residual count
          if (st_ff.dreq.sel[`BSTC_T_DMAR] || st_ff.dreq.sel[`BSTC_T_DMAW]) begin
            nxt_st.brk = diag_rsp_i.count;
          end
          // RULE9 readback stored
          if (st_ff.dreq.sel[`BSTC_T_SACC] && diag_rsp_i.word_vld) begin
            nxt_st.bbase = diag_rsp_i.word;
          end
          nxt_st.fsm = ST_DONE;
        end
      end
      ST_IRQ: begin
        if (st_ff.ack_s2) begin
          nxt_st.irq  = 1'b0;
          nxt_st.code = `BSTC_C_PASS;
          nxt_st.fsm  = ST_DONE;
        end else if (tmo_exp) begin
          // RULE13 timeout code
          nxt_st.irq  = 1'b0;
          nxt_st.code = `BSTC_C_IRQTMO;
          nxt_st.fsm  = ST_DONE;
        end
      end
      ST_DONE: begin
        // RULE2 completion clears
        nxt_st.cmd0.self_test = 1'b0;
        nxt_st.busy          = 1'b0;
        // RULE3 outcome flag
        nxt_st.fail = (st_ff.code != `BSTC_C_PASS);
        // RULE4 code to channel zero
        nxt_st.code_we = (st_ff.code != `BSTC_C_PASS);
        nxt_st.fsm     = ST_IDLE;
      end
      default: nxt_st.fsm = ST_IDLE;
    endcase

    // Whole-board reset returns every register to its reset value
    if (st_ff.brd_rst) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata_o     = st_ff.rdata;
  assign irq_req_o       = st_ff.irq;
  assign irq_level_o     = st_ff.eic[2:0];
  assign irq_vector_o    = st_ff.evec;
  assign diag_req_o      = st_ff.dreq;
  assign chan0_code_we_o = st_ff.code_we;
  assign chan0_code_o    = st_ff.code;
  assign board_reset_o   = st_ff.brd_rst;
  assign cmd0_o          = st_ff.cmd0;
  assign cmd1_o          = st_ff.cmd1;
  assign cmd2_o          = st_ff.cmd2;
  assign wam_o           = st_ff.wam;
  assign run_o           = st_ff.run;
  assign tx_req_o        = st_ff.txr;
  assign rx_req_o        = st_ff.rxr;
  assign brk_o           = st_ff.brk;
  assign bbase_o         = st_ff.bbase;
  assign mgrn_o          = st_ff.mgrn;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  property p_done_clr;
    st_ff.fsm == ST_DONE && !st_ff.brd_rst |=> !st_ff.cmd0.self_test && !st_ff.busy;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("test end left busy"); // RULE2

  property p_fail_set;
    st_ff.fsm == ST_DONE && st_ff.code != 8'h00 && !st_ff.brd_rst |=> st_ff.fail && gstat[10];
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("fail flag not set"); // RULE3

  property p_code_out;
    chan0_code_we_o |-> $past(st_ff.fsm) == ST_DONE && chan0_code_o != 8'h00;
  endproperty
  a_code_out: assert property (p_code_out) else $error("bad code strobe"); // RULE4

  property p_undef;
    st_ff.fsm == ST_IDLE && st_ff.cmd0.self_test && st_ff.tsel[7:6] != 2'b00
      && !st_ff.brd_rst && !reg_wr_i |=> st_ff.code == 8'hff ##1 st_ff.fail;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined test not coded"); // RULE17

  property p_irq_bad;
    st_ff.fsm == ST_IDLE && st_ff.cmd0.self_test && st_ff.tsel == 8'h01
      && st_ff.eic == 8'h00 && !st_ff.brd_rst |=> st_ff.code == 8'h07 && !irq_req_o;
  endproperty
  a_irq_bad: assert property (p_irq_bad) else $error("bad irq setup missed"); // RULE13

  property p_irq_tmo;
    st_ff.fsm == ST_IRQ && tmo_exp && !st_ff.ack_s2 && !st_ff.brd_rst
      |=> st_ff.code == 8'h06 && !irq_req_o;
  endproperty
  a_irq_tmo: assert property (p_irq_tmo) else $error("irq timeout code wrong"); // RULE13

  property p_irq_held;
    st_ff.fsm == ST_IRQ |-> irq_req_o && irq_level_o != 3'h0;
  endproperty
  a_irq_held: assert property (p_irq_held) else $error("irq not raised"); // RULE12

  property p_dma_res;
    st_ff.fsm == ST_RUN && diag_rsp_i.done && st_ff.dreq.sel[5] && !st_ff.brd_rst
      |=> brk_o == $past(diag_rsp_i.count) ##1 !st_ff.busy;
  endproperty
  a_dma_res: assert property (p_dma_res) else $error("residual not kept"); // RULE7

  property p_sacc;
    st_ff.fsm == ST_RUN && diag_rsp_i.done && diag_rsp_i.word_vld && st_ff.dreq.sel[3]
      && !st_ff.brd_rst |=> bbase_o == $past(diag_rsp_i.word);
  endproperty
  a_sacc: assert property (p_sacc) else $error("readback not stored"); // RULE9

endmodule // bstc_top

/* File: logic/bstc_regs.svh */
// Offsets, field positions, reset values and timing counts of the self-test control.
// Assumes byte-wide register access at the printed offsets, big-endian words.
`ifndef BSTC_REGS_SVH
`define BSTC_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BSTC_A_ID    5'h00
`define BSTC_A_STF   5'h01
`define BSTC_A_OPTH  5'h02
`define BSTC_A_OPTL  5'h03
`define BSTC_A_CMD0  5'h04
`define BSTC_A_CMD1  5'h05
`define BSTC_A_RUNH  5'h06
`define BSTC_A_RUNL  5'h07
`define BSTC_A_TXH   5'h08
`define BSTC_A_TXL   5'h09
`define BSTC_A_RXH   5'h0a
`define BSTC_A_RXL   5'h0b
`define BSTC_A_BRKH  5'h0c
`define BSTC_A_BRKL  5'h0d
`define BSTC_A_CMD2  5'h0e
`define BSTC_A_WAM   5'h10
`define BSTC_A_TSEL  5'h11
`define BSTC_A_EIC   5'h12
`define BSTC_A_EVEC  5'h13
`define BSTC_A_BB0   5'h14
`define BSTC_A_GSTH  5'h18
`define BSTC_A_GSTL  5'h19
`define BSTC_A_MGRN  5'h1a
// ----------------------------------------
// Fields, codes and timing
// ----------------------------------------
`define BSTC_T_BINT    0
`define BSTC_T_SACC    3
`define BSTC_T_DMAW    4
`define BSTC_T_DMAR    5
`define BSTC_GH_BUSY   5
`define BSTC_GH_SYSC   4
`define BSTC_GH_FAIL   2
`define BSTC_C_PASS    8'h00
`define BSTC_C_IRQTMO  8'h06
`define BSTC_C_IRQBAD  8'h07
`define BSTC_C_UNDEF   8'hff
`define BSTC_RST8      8'h00
`define BSTC_CLK_NS    25
`define BSTC_MS_NS     1000000
`define BSTC_IRQ_TMO_MS 10
`endif

/* File: logic/bstc_pkg.sv */
// Types shared by the self-test control and its diagnostic engine.
// Constants live in bstc_regs.svh.
package bstc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11,
    ST_IRQ  = 2'b10
  } bstc_fsm_t;
  typedef struct packed {
    logic master, slave_decode_enable, slv_wide, sup_only, send_brk, self_test, brd_rst, ind_off;
  } bstc_cmd0_t;
  typedef struct packed {
    logic [3:0] rsv;
    logic       arb_sel;
    logic [2:0] buserr_to;
  } bstc_cmd1_t;
  typedef struct packed {
    logic [1:0] req_lvl;
    logic [1:0] rel_pol;
    logic [3:0] fairness_timeout;
  } bstc_cmd2_t;
  typedef struct packed {
    logic [1:0] width;
    logic [5:0] am;
  } bstc_wam_t;
  typedef struct packed {
    logic       start;
    logic [5:0] sel;
  } bstc_dreq_t;
  typedef struct packed {
    logic        done;
    logic [7:0]  code;
    logic [15:0] count;
    logic        word_vld;
    logic [31:0] word;
  } bstc_drsp_t;
endpackage

/* File: logic/bstc_tmo.sv */
// Millisecond timeout counter for the self-test control.
// Assumes one clock; clr_i restarts the count, run_i lets it advance.
`timescale 1ns/1ps
`include "bstc_regs.svh"
module bstc_tmo #(
  parameter int MS_CYC   = `BSTC_MS_NS / `BSTC_CLK_NS,
  parameter int LIMIT_MS = `BSTC_IRQ_TMO_MS
) (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic clr_i,
  input  wire logic run_i,
  output logic      expired_o
);
  import bstc_pkg::*;
  typedef struct packed {
    logic [17:0] div;
    logic [7:0]  ms;
    logic        exp;
  } bstc_tmo_st_t;
  bstc_tmo_st_t st_ff;
  bstc_tmo_st_t nxt_st;
  // ----------------------------------------
  // Divider gives a one-cycle ms enable
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (clr_i) begin
      nxt_st = '0;
    end else if (run_i && !st_ff.exp) begin
      if (st_ff.div == 18'(MS_CYC - 1)) begin
        nxt_st.div = '0;
        nxt_st.ms  = st_ff.ms + 8'h01;
        // Longest wait rounds down, so flag at the limit itself
        if (st_ff.ms == 8'(LIMIT_MS - 1)) nxt_st.exp = 1'b1;
      end else begin
        nxt_st.div = st_ff.div + 18'h00001;
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) st_ff <= '0;
    else st_ff <= nxt_st;
  end
  assign expired_o = st_ff.exp;
endmodule // bstc_tmo

/* File: verification/bstc_engine_model.sv */
// Behavioural diagnostic engine that answers the self-test control.
// Assumes the same clock; each start is answered DLY+1 cycles later.
`timescale 1ns/1ps
module bstc_engine_model
  import bstc_pkg::*;
#(
  parameter int DLY = 6
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_b_i,
  input  wire bstc_pkg::bstc_dreq_t req_i,
  input  wire logic [7:0]           code_i,
  input  wire logic                 wvld_i,
  output bstc_pkg::bstc_drsp_t      rsp_o
);
  import bstc_pkg::*;
  int cnt;
  // residue and word
  // Fields toggle outside done so that a stale value is never trusted
  always_ff @(posedge mclk_i) begin
    rsp_o <= {1'b0, ~rsp_o[56:0]};
    if (!rst_b_i) begin
      rsp_o <= '0;
      cnt <= -1;
    end else if (req_i.start) begin
      cnt <= DLY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (cnt == 0) begin
      rsp_o <= {1'b1, code_i, 16'h0004, wvld_i, 32'hc0de0004};
      cnt <= -1;
    end
  end
endmodule // bstc_engine_model

/* File: verification/board_self_test_control_tb.sv */
// Bench for the self-test control: register tasks, test runs, checks.
// Assumes bstc_engine_model answers the diagnostic port.
`timescale 1ns/1ps
`include "bstc_regs.svh"
module board_self_test_control_tb;
  import bstc_pkg::*;
  localparam int MSC = 20;
  logic       mclk_i = 0;
  logic       rst_b_i = 0;
  logic       wr = 0;
  logic       rd = 0;
  logic       ack = 0;
  logic       ack_en = 0;
  logic       got_irq = 0;
  logic [4:0] ad = '0;
  logic [7:0] wd = '0;
  logic [7:0] mc = '0;
  logic [7:0] rdat, ccode, seen, ivec, gvec;
  logic [2:0] ilvl, glvl;
  logic       ireq, cwe, brst;
  bstc_dreq_t dreq;
  bstc_drsp_t drsp;
  bstc_cmd0_t cmd0;
  bstc_cmd1_t cmd1;
  bstc_cmd2_t cmd2;
  logic [15:0] runo, txo, rxo, brko;
  logic [31:0] bbo;
  logic [7:0]  mgo;
  bstc_wam_t  wam;
  int         fails = 0;
  int         comparisons = 0;
  int         nwe = 0;
  int         nrst = 0;
  int         cyc = 0;
  int         dur = 0;
  bstc_top #(.MS_CYC(MSC), .BOARD_ID(8'h3c)) DUT ( // arbitrary value
    .mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(ad), .reg_wdata_i(wd),
    .reg_rdata_o(rdat), .sys_ctrl_pin_i(1'b1),
    .irq_ack_pin_i(ack), .irq_req_o(ireq),
    .irq_level_o(ilvl), .irq_vector_o(ivec),
    .diag_req_o(dreq), .diag_rsp_i(drsp),
    .chan0_code_we_o(cwe), .chan0_code_o(ccode),
    .board_reset_o(brst), .cmd0_o(cmd0),
    .cmd1_o(cmd1), .cmd2_o(cmd2), .wam_o(wam),
    .run_o(runo), .tx_req_o(txo), .rx_req_o(rxo), .brk_o(brko),
    .bbase_o(bbo), .mgrn_o(mgo)
  );
  bstc_engine_model ENG (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(dreq),
    .code_i(mc), .wvld_i(1'b1), .rsp_o(drsp)
  );
  // 25 ns clock
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  // Strobe counts, irq capture, host ack, hang guard (mid-cycle sampling)
  always @(negedge mclk_i) begin
    cyc++;
    // An unknown strobe counts as a pulse rather than vanishing
    nwe += (cwe !== 1'b0);
    nrst += (brst !== 1'b0);
    ack <= ireq & ack_en;
    if (ireq === 1'b1) begin
      got_irq = 1;
      glvl = ilvl;
      gvec = ivec;
    end
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr8(input logic [4:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    ad = a;
    wd = d;
    wr = 1;
    @(negedge mclk_i);
    wr = 0;
  endtask
  // Data is registered, so it is taken one cycle after the read edge
  task automatic rd8(input logic [4:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    ad = a;
    rd = 1;
    @(negedge mclk_i);
    rd = 0;
    @(negedge mclk_i);
    d = rdat;
  endtask
  // One self-test: host setup, trigger, poll busy, check outcome
  task automatic run(input logic [7:0] sel, input logic [7:0] m, input logic [7:0] e);
    int n;
    int t0;
    mc = m;
    wr8(`BSTC_A_RUNH, 8'h00);
    wr8(`BSTC_A_RUNL, 8'h00);
    wr8(`BSTC_A_BRKH, 8'h00);
    wr8(`BSTC_A_BRKL, 8'h10);
    wr8(`BSTC_A_BB0 + 5'h3, 8'h55);
    // Fail flag is kept here, so a pass must clear it in hardware
    wr8(`BSTC_A_GSTH, 8'h04);
    wr8(`BSTC_A_TSEL, sel);
    n = nwe;
    got_irq = 0;
    wr8(`BSTC_A_CMD0, 8'h04);
    t0 = cyc;
    repeat (2) @(negedge mclk_i);
    if (sel == 8'h02) repeat (5 * MSC) @(negedge mclk_i);
    for (int i = 0; i < 300; i++) begin
      rd8(`BSTC_A_STF, seen);
      if (seen[0] !== 1'b1) break;
    end
    dur = cyc - t0;
    chk(seen[0], 1'b0);
    rd8(`BSTC_A_CMD0, seen);
    chk(seen[2], 1'b0);
    rd8(`BSTC_A_GSTH, seen);
    chk(seen, (e != 8'h00) ? 8'h94 : 8'h10);
    chk(ccode, e);
    chk(nwe - n, e != 8'h00);
    rd8(`BSTC_A_BRKL, seen);
    chk(seen, (sel[5] | sel[4]) ? 8'h04 : 8'h10);
    rd8(`BSTC_A_BB0 + 5'h3, seen);
    chk(seen, (sel == 8'h08) ? 8'h04 : 8'h55);
    chk(brko, (sel[5] | sel[4]) ? 16'h0004 : 16'h0010);
    chk(runo, 16'h0000);
    if (sel == 8'h08) chk(bbo, 32'hc0de0004);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] ts [14];
    logic [7:0] ms [14];
    logic [7:0] ie [4];
    logic [7:0] iex [4];
    ts = '{8'h20, 8'h20, 8'h10, 8'h08, 8'h08, 8'h08, 8'h04, 8'h04,
           8'h02, 8'h02, 8'h80, 8'h40, 8'h00, 8'h03};
    ms = '{8'h01, 8'h00, 8'h02, 8'h03, 8'h08, 8'h00, 8'h13, 8'h00,
           8'h04, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
    ie = '{8'h03, 8'h07, 8'h00, 8'h0b};
    iex = '{8'h00, 8'h06, 8'h07, 8'h07};
    repeat (3) @(negedge mclk_i);
    rst_b_i = 1;
    chk({cmd0, cmd1, cmd2, wam}, 32'h0);
    wr8(`BSTC_A_ID, 8'hff);
    rd8(`BSTC_A_ID, seen);
    chk(seen, 8'h3c);
    wr8(5'h1c, 8'h00);
    rd8(5'h1c, seen);
    chk(seen, 8'h00);
    wr8(`BSTC_A_CMD0, 8'h41);
    wr8(`BSTC_A_CMD1, 8'h0b);
    wr8(`BSTC_A_CMD2, 8'hd6);
    wr8(`BSTC_A_WAM, 8'h85);
    wr8(`BSTC_A_TXH, 8'h12);
    wr8(`BSTC_A_TXL, 8'h34);
    wr8(`BSTC_A_RXH, 8'h56);
    wr8(`BSTC_A_RXL, 8'h78);
    wr8(`BSTC_A_MGRN, 8'h9a);
    wr8(`BSTC_A_RUNH, 8'hbc);
    @(negedge mclk_i);
    chk(cmd0, 8'h41);
    chk({cmd1.arb_sel, cmd1.buserr_to}, 4'hb);
    chk({cmd2.req_lvl, cmd2.rel_pol, cmd2.fairness_timeout}, 8'hd6);
    chk({txo, rxo}, 32'h12345678);
    chk({runo, mgo}, 24'hbc009a);
    chk({wam.width, wam.am}, 8'h85);
    // Every engine test code, then undefined selections
    for (int i = 0; i < 14; i++) begin
      run(ts[i], ms[i], ($onehot(ts[i]) && ts[i][7:6] == 2'b00) ? ms[i] : 8'hff);
    end
    // Host clear of the fail flag left by the last undefined run
    wr8(`BSTC_A_GSTH, 8'h00);
    rd8(`BSTC_A_GSTH, seen);
    chk(seen, 8'h10);
    // Interrupt test: acked, timed out, two bad setups
    for (int i = 0; i < 4; i++) begin
      ack_en = (i == 0);
      wr8(`BSTC_A_EIC, ie[i]);
      wr8(`BSTC_A_EVEC, 8'h81);
      run(8'h01, 8'h00, iex[i]);
      chk(got_irq, iex[i] != 8'h07);
      if (i < 2) chk({glvl, gvec}, {ie[i][2:0], 8'h81});
      if (i == 1) chk(dur >= 10 * MSC && dur < 10 * MSC + 60, 1'b1);
    end
    wr8(`BSTC_A_CMD0, 8'h02);
    repeat (3) @(negedge mclk_i);
    chk(nrst, 1);
    chk({txo, rxo}, 32'h0);
    rd8(`BSTC_A_CMD2, seen);
    chk(seen, 8'h00);
    tally_and_finish();
  end
endmodule // board_self_test_control_tb
